// >>> core/bsrg_pkg.sv
// bsrg_pkg: shared constants for the boot strap and reset glue controller.
// assumes a single 125 MHz clock domain and a 24-bit word address bus.
package bsrg_pkg;
    // clock rate and reset stretch timing
    localparam int          CLK_MHZ         = 125;
    localparam int          RST_HOLD_US     = 100;  // stretch after last cause clears
    localparam int          RST_HOLD_CYC    = RST_HOLD_US * CLK_MHZ;
    localparam int          BTN_DEB_US      = 20;   // button must stay released
    localparam int          BTN_DEB_CYC     = BTN_DEB_US * CLK_MHZ;
    // boot mode codes, as the processor reads its three select pins
    typedef enum logic [2:0] {
        BSRG_BOOT_NOLOAD16 = 3'h0,
        BSRG_BOOT_SPI24    = 3'h1,
        BSRG_BOOT_SERIAL16 = 3'h2,
        BSRG_BOOT_PAR16    = 3'h3,
        BSRG_BOOT_NOLOAD32 = 3'h4,
        BSRG_BOOT_HOSTPORT = 3'h5,
        BSRG_BOOT_I2C      = 3'h6,
        BSRG_BOOT_UART     = 3'h7
    } bsrg_boot_t;
    localparam logic [2:0]  BOOT_DEFAULT    = 3'h3;
    localparam logic [23:0] RESET_VECTOR    = 24'hFFFF00;
    // chip-enable-one space decode
    localparam int          ADDR_W          = 24;
    localparam logic [23:0] CE1_BASE        = 24'h200000;
    localparam logic [23:0] REGBANK_BASE    = 24'h380000;
    localparam int          CE_SEL_HI       = 22;   // word address bits 22 and 21 pick the space
    localparam int          CE_SEL_LO       = 21;
    localparam int          HALF_BIT        = 20;   // splits the space in halves
    localparam logic [1:0]  CE1_CODE        = 2'h0 + CE1_BASE[22:21];
    localparam int          REGBANK_IDX_LSB = 19;   // upper half inside the half
endpackage

// >>> core/bsrg_sync.sv
// bsrg_sync: two flop synchroniser for one asynchronous level.
// assumes the input comes from a pin or another clock.
`timescale 1ns/1ps
`default_nettype none
module bsrg_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;  // first stage, only read by the second
    // two stages give metastability time to settle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> core/bsrg_hold.sv
// bsrg_hold: counts cycles that a level stays high, reports when it reached a limit.
// assumes a synchronised input on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bsrg_hold #(
    parameter int CYCLES = 16
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic level_in,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(CYCLES);
    logic [CW-1:0] cnt_r;  // cycles seen high in a row
    // any low restarts the count, so a glitch never shortens the wait
    always_ff @(posedge clk) begin
        if (sys_rst || !level_in) begin
            cnt_r <= '0;
        end else if (cnt_r != LIMIT) begin
            cnt_r <= cnt_r + CW'(1);
        end
    end
    assign done = (cnt_r == LIMIT);
endmodule
`default_nettype wire

// >>> core/bsrg_glue.sv
// bsrg_glue: straps, reset aggregation and chip-enable-one split for the processor.
// assumes one 125 MHz clock; button, supervisors and strap jumpers arrive as raw pins.
//
// Operation
// - processor latches boot pins at reset
// - nonzero code runs loader from internal ROM
// - code 000 starts external 16-bit, no load
// - code 001 loads from SPI serial port zero
// - code 010 standard 16-bit serial boot
// - code 011 parallel flash boot, board default
// - one code starts 32-bit, no load
// - codes 101/110/111 host port, I2C, UART
// - table boot copies code then jumps entry
// - memory clock strap high picks external clock
`timescale 1ns/1ps
`default_nettype none
module bsrg_glue
    import bsrg_pkg::*;
#(
    parameter int NUM_SUP   = 3,
    parameter int HOLD_CYC  = RST_HOLD_CYC,
    parameter int DEB_CYC   = BTN_DEB_CYC
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              button_n,            // low while pressed
    input  wire logic [NUM_SUP-1:0] supervisor_rst_n,   // low while a rail is out
    input  wire logic [2:0]        boot_jumper_fitted,  // 1 = jumper on
    input  wire logic              memclk_jumper_fitted,
    input  wire logic [ADDR_W-1:0] proc_addr,           // word address from processor
    input  wire logic              proc_strobe,         // access in progress
    output logic                   global_rst_n,
    output logic [2:0]             boot_mode_code,
    output logic                   memory_clock_strap,
    output logic                   flash_sel,
    output logic                   regbank_sel,
    output logic                   chip_enable_one_space,
    output logic [2:0]             latched_boot_code,   // code seen at last release
    output logic                   boot_is_table_load,  // latched code loads a table
    output logic                   boot_is_noload       // latched code runs in place
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    // every strap, button and supervisor pin is asynchronous to clk; none is read raw,
    // so a jumper moved mid-cycle cannot make a strap metastable; each of its bits settles on its own edge
    logic                   btn_up_s;   // button released
    logic [NUM_SUP-1:0]     sup_ok_s;   // each rail good
    logic [2:0]             jmp_s;      // boot jumpers
    logic                   mjmp_s;     // memory clock jumper

    bsrg_sync #(.RST_VAL(1'b0)) u_btn (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (button_n),
        .sync_out (btn_up_s)
    );

    // one synchroniser per rail and per jumper
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SUP; gi++) begin : g_sup
            bsrg_sync #(.RST_VAL(1'b0)) u_sup (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .async_in (supervisor_rst_n[gi]),
                .sync_out (sup_ok_s[gi])
            );
        end
        for (gi = 0; gi < 3; gi++) begin : g_jmp
            bsrg_sync #(.RST_VAL(1'b0)) u_jmp (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .async_in (boot_jumper_fitted[gi]),
                .sync_out (jmp_s[gi])
            );
        end
    endgenerate

    bsrg_sync #(.RST_VAL(1'b0)) u_mjmp (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (memclk_jumper_fitted),
        .sync_out (mjmp_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset aggregation
    logic all_ok;     // every cause quiet this cycle
    logic btn_done;   // button steady released
    logic hold_done;  // everything quiet long enough

    // any low supervisor or a pressed button keeps the board in reset
    assign all_ok = (&sup_ok_s) & btn_up_s;

    bsrg_hold #(.CYCLES(DEB_CYC)) u_deb (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .level_in (btn_up_s),
        .done     (btn_done)
    );

    // the stretch restarts on every new cause, so bounce cannot slip through
    bsrg_hold #(.CYCLES(HOLD_CYC)) u_hold (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .level_in (all_ok & btn_done),
        .done     (hold_done)
    );

    logic rst_active_r;  // global reset asserted
    // asserted at once on a cause, released only after the stretch
    // a new cause wins over a finished stretch in the same cycle,
    // so a rail dropping at the release edge still keeps the board held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_active_r <= 1'b1;
        end else if (!all_ok) begin
            rst_active_r <= 1'b1;
        end else if (hold_done) begin
            rst_active_r <= 1'b0;
        end
    end
    assign global_rst_n = ~rst_active_r;

    ////////////////////////////////////////////////////////////////////////
    // strap drive
    logic [2:0] boot_r;  // boot pins as driven
    logic       mclk_r;  // memory clock strap as driven

    // straps follow the jumpers only outside reset, frozen while it holds;
    // limitation: a jumper moved during reset counts only from the next reset
    // on, since the processor samples what was driven when reset began
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_r <= BOOT_DEFAULT;
            mclk_r <= 1'b1;
        end else if (!rst_active_r) begin
            boot_r <= ~jmp_s;
            mclk_r <= ~mjmp_s;
        end
    end
    assign boot_mode_code     = boot_r;
    assign memory_clock_strap = mclk_r;

    ////////////////////////////////////////////////////////////////////////
    // sampled mode at release, as the processor will see it
    logic       rst_q_r;   // reset one cycle ago
    logic [2:0] seen_r;    // code captured at release
    logic       table_r;   // captured code loads a table
    logic       noload_r;  // captured code starts in place

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_q_r <= 1'b1;
        end else begin
            rst_q_r <= rst_active_r;
        end
    end

    // a release edge catches the code that the processor latches
    // the copy mirrors the processor's own sample, for status and checks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seen_r   <= BOOT_DEFAULT;
            table_r  <= 1'b1;
            noload_r <= 1'b0;
        end else if (rst_q_r && !rst_active_r) begin
            seen_r <= boot_r;
            unique case (bsrg_boot_t'(boot_r))
                BSRG_BOOT_NOLOAD16: begin
                    table_r  <= 1'b0;
                    noload_r <= 1'b1;
                end
                BSRG_BOOT_NOLOAD32: begin
                    table_r  <= 1'b0;
                    noload_r <= 1'b1;
                end
                BSRG_BOOT_SPI24,
                BSRG_BOOT_SERIAL16,
                BSRG_BOOT_PAR16,
                BSRG_BOOT_HOSTPORT,
                BSRG_BOOT_I2C,
                BSRG_BOOT_UART: begin
                    table_r  <= 1'b1;
                    noload_r <= 1'b0;
                end
            endcase
        end
    end
    assign latched_boot_code  = seen_r;
    assign boot_is_table_load = table_r;
    assign boot_is_noload     = noload_r;

    ////////////////////////////////////////////////////////////////////////
    // chip-enable-one split
    logic in_ce1;   // address in the space
    logic upper;    // upper half of it

    assign in_ce1 = proc_addr[CE_SEL_HI:CE_SEL_LO] == CE1_BASE[CE_SEL_HI:CE_SEL_LO];
    assign upper  = proc_addr[HALF_BIT] == REGBANK_BASE[HALF_BIT];

    // selects register for clean, glitch free chip selects
    // costs one cycle of latency; the bus strobe is already on clk, so no
    // synchroniser sits on the address path
    always_ff @(posedge clk) begin
        if (sys_rst || rst_active_r) begin
            flash_sel             <= 1'b0;
            regbank_sel           <= 1'b0;
            chip_enable_one_space <= 1'b0;
        end else begin
            chip_enable_one_space <= proc_strobe & in_ce1;
            flash_sel             <= proc_strobe & in_ce1 & ~upper;
            regbank_sel           <= proc_strobe & in_ce1 & upper
                & (proc_addr[REGBANK_IDX_LSB] == REGBANK_BASE[REGBANK_IDX_LSB]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // all properties run on clk and are off while sys_rst holds;
    // they watch the outputs against all_ok, jmp_s and the bus inputs, so they also guard the registered copies
    property p_rst_on_cause;
        @(posedge clk) disable iff (sys_rst) !all_ok |=> !global_rst_n;
    endproperty
    a_rst_on_cause: assert property (p_rst_on_cause) else $error("reset not held");

    property p_rst_release;
        @(posedge clk) disable iff (sys_rst) $rose(global_rst_n) |-> $past(all_ok);
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("early release");

    property p_strap_frozen;
        @(posedge clk) disable iff (sys_rst)
            (!global_rst_n && $past(!global_rst_n)) |-> $stable(boot_mode_code);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) else $error("strap moved");

    property p_jumper_level;
        @(posedge clk) disable iff (sys_rst)
            global_rst_n ##1 global_rst_n |-> boot_mode_code == ~$past(jmp_s);
    endproperty
    a_jumper_level: assert property (p_jumper_level) else $error("strap level");

    property p_latch_code;
        @(posedge clk) disable iff (sys_rst)
            $rose(global_rst_n) |=> latched_boot_code == $past(boot_mode_code);
    endproperty
    a_latch_code: assert property (p_latch_code) else $error("code not latched");

    property p_noload;
        @(posedge clk) disable iff (sys_rst)
            boot_is_noload |-> (latched_boot_code == 3'h0 || latched_boot_code == 3'h4);
    endproperty
    a_noload: assert property (p_noload) else $error("noload code");

    property p_split;
        @(posedge clk) disable iff (sys_rst) !(flash_sel && regbank_sel);
    endproperty
    a_split: assert property (p_split) else $error("both halves");

    property p_regbank_addr;
        @(posedge clk) disable iff (sys_rst)
            (global_rst_n && proc_strobe && proc_addr == REGBANK_BASE) |=> regbank_sel;
    endproperty
    a_regbank_addr: assert property (p_regbank_addr) else $error("bank miss");

    // a flash word must never reach the register bank
    property p_flash_addr;
        @(posedge clk) disable iff (sys_rst)
            (global_rst_n && proc_strobe && proc_addr == CE1_BASE)
            |=> (flash_sel && chip_enable_one_space && !regbank_sel);
    endproperty
    a_flash_addr: assert property (p_flash_addr) else $error("flash miss");

    // other spaces belong to other devices, so the space select stays off
    property p_other_space;
        @(posedge clk) disable iff (sys_rst)
            (proc_addr[CE_SEL_HI:CE_SEL_LO] != CE1_BASE[CE_SEL_HI:CE_SEL_LO])
            |=> !chip_enable_one_space;
    endproperty
    a_other_space: assert property (p_other_space) else $error("foreign space");

    // no chip select may fire while the board is held in reset
    property p_sel_in_reset;
        @(posedge clk) disable iff (sys_rst)
            !global_rst_n |=> !(chip_enable_one_space || flash_sel || regbank_sel);
    endproperty
    a_sel_in_reset: assert property (p_sel_in_reset) else $error("select in reset");

    // the memory clock strap is sampled too, so it freezes like the boot pins
    property p_mclk_frozen;
        @(posedge clk) disable iff (sys_rst)
            (!global_rst_n && $past(!global_rst_n)) |-> $stable(memory_clock_strap);
    endproperty
    a_mclk_frozen: assert property (p_mclk_frozen) else $error("clock strap moved");

    // a table load is never flagged for one of the two in-place codes
    property p_table_code;
        @(posedge clk) disable iff (sys_rst)
            boot_is_table_load |-> !(latched_boot_code inside {3'h0, 3'h4});
    endproperty
    a_table_code: assert property (p_table_code) else $error("table code");
endmodule
`default_nettype wire

// >>> sim/bsrg_proc_model.sv
// bsrg_proc_model: behavioural processor side, samples straps when reset releases.
// assumes strap and reset levels arrive already settled on the glue clock.
`timescale 1ns/1ps
`default_nettype none
module bsrg_proc_model
    import bsrg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       global_rst_n,
    input  wire logic [2:0] boot_mode_code,
    input  wire logic       memory_clock_strap,
    output logic [2:0]      seen_code,   // code taken at release
    output logic            rom_active,  // loader runs from internal rom
    output logic            loads_table, // boot copies a table, then jumps
    output logic            ext_memclk   // external memory clock chosen
);
    logic rst_n_r;  // last reset level, finds the release edge
    ////////////////////////////////////////////////////////////////////////
    // previous reset level
    always_ff @(posedge clk) begin
        rst_n_r <= global_rst_n;
    end
    // straps only count on the release edge; later changes are ignored
    always_ff @(posedge clk) begin
        if (global_rst_n && !rst_n_r) begin
            seen_code   <= boot_mode_code;
            rom_active  <= (boot_mode_code != BSRG_BOOT_NOLOAD16);
            loads_table <= (boot_mode_code != BSRG_BOOT_NOLOAD16)
                && (boot_mode_code != BSRG_BOOT_NOLOAD32);
            ext_memclk  <= memory_clock_strap;
        end
    end
endmodule
`default_nettype wire

// >>> sim/test_boot_strap_reset_glue.sv
// test_boot_strap_reset_glue: self-checking bench for the strap and reset glue.
// assumes the glue and the processor model; short hold counts keep runs brief.
`timescale 1ns/1ps
`default_nettype none
module test_boot_strap_reset_glue;
    import bsrg_pkg::*;
    localparam int HOLD = 8;  // shortened stretch
    localparam int DEB  = 4;  // shortened debounce
    logic        clk, sys_rst, button_n, memclk_fit, strobe, grst_n, mcs;
    logic [2:0]  sup_n, boot_fit, code, lcode, m_code;
    logic [23:0] addr;
    logic        fsel, rsel, ce1, tbl, nold, m_rom, m_tbl, m_ext;
    int          error_cnt, num_checks;
    bsrg_glue #(.NUM_SUP(3), .HOLD_CYC(HOLD), .DEB_CYC(DEB)) bsrg_glue_inst (
        .clk(clk), .sys_rst(sys_rst), .button_n(button_n), .supervisor_rst_n(sup_n),
        .boot_jumper_fitted(boot_fit), .memclk_jumper_fitted(memclk_fit),
        .proc_addr(addr), .proc_strobe(strobe), .global_rst_n(grst_n),
        .boot_mode_code(code), .memory_clock_strap(mcs), .flash_sel(fsel),
        .regbank_sel(rsel), .chip_enable_one_space(ce1), .latched_boot_code(lcode),
        .boot_is_table_load(tbl), .boot_is_noload(nold));
    bsrg_proc_model bsrg_proc_model_inst (
        .clk(clk), .global_rst_n(grst_n), .boot_mode_code(code),
        .memory_clock_strap(mcs), .seen_code(m_code), .rom_active(m_rom),
        .loads_table(m_tbl), .ext_memclk(m_ext));
    ////////////////////////////////////////////////////////////////////////
    // clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // one-bit results
    task automatic check_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    // three-bit results: codes and select triples
    task automatic check_code(input string what, input logic [2:0] exp,
                              input logic [2:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // verdict, also reached from a spent wait
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // count falling edges until global reset lifts, bounded
    task automatic wait_release(output int n);
        n = 0;
        while (grst_n !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 80) begin
                error_cnt++;
                $display("ERROR release wait expired");
                conclude();
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // straps default and selects stay quiet while sys_rst holds
    task automatic test_reset_default;
        addr   = REGBANK_BASE;
        strobe = 1'b1;
        @(negedge clk);
        check_code("default code", BOOT_DEFAULT, code);
        check_bit("reset out", 1'b0, grst_n);
        check_code("sels in reset", 3'h0, {ce1, fsel, rsel});
        strobe = 1'b0;
    endtask
    // every boot code, with jumper noise during reset
    task automatic test_boot_codes;
        int n;
        for (int c = 0; c < 8; c++) begin
            boot_fit = ~c[2:0];
            repeat (5) @(negedge clk);
            check_code("strap level", c[2:0], code);
            button_n = 1'b0;
            repeat (5) @(negedge clk);
            check_bit("button reset", 1'b0, grst_n);
            boot_fit = c[2:0];
            repeat (5) @(negedge clk);
            check_code("frozen strap", c[2:0], code);
            boot_fit = ~c[2:0];
            repeat (3) @(negedge clk);
            button_n = 1'b1;
            wait_release(n);
            check_bit("held long enough", 1'b1, n >= DEB + HOLD);
            @(negedge clk);
            check_code("latched code", c[2:0], lcode);
            check_code("model code", c[2:0], m_code);
            check_bit("table flag", m_tbl, tbl);
            check_bit("noload flag", !m_tbl, nold);
            check_bit("rom use", c != 0, m_rom);
        end
    endtask
    // each supervisor alone resets the board; clock strap follows jumper
    task automatic test_supervisors;
        int n;
        for (int i = 0; i < 3; i++) begin
            memclk_fit = i[0];
            repeat (5) @(negedge clk);
            check_bit("clock strap pin", !i[0], mcs);
            sup_n[i] = 1'b0;
            repeat (5) @(negedge clk);
            check_bit("supervisor reset", 1'b0, grst_n);
            sup_n[i] = 1'b1;
            wait_release(n);
            check_bit("supply hold", 1'b1, n >= HOLD + 2);
            @(negedge clk);
            check_bit("clock strap", !i[0], m_ext);
        end
    endtask
    // back-to-back decode across both halves and outside the space
    task automatic test_decode;
        logic [23:0] tab [6];
        logic [2:0]  exp_sel [6];
        tab = '{REGBANK_BASE, CE1_BASE, 24'h300000, 24'h400000, 24'h180000, REGBANK_BASE};
        // {space, flash, bank}: flash in the lower half, bank in the upper half of the upper half
        exp_sel = '{3'h5, 3'h6, 3'h4, 3'h0, 3'h0, 3'h5};
        strobe = 1'b1;
        for (int k = 0; k < 6; k++) begin
            addr = tab[k];
            @(negedge clk);
            check_code("decode", exp_sel[k], {ce1, fsel, rsel});
        end
        strobe = 1'b0;
        @(negedge clk);
        check_code("idle decode", 3'h0, {ce1, fsel, rsel});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int n;
        error_cnt  = 0;
        num_checks = 0;
        sys_rst    = 1'b1;
        button_n   = 1'b1;
        sup_n      = 3'h7;
        boot_fit   = 3'h4;
        memclk_fit = 1'b0;
        addr       = 24'h000000;
        strobe     = 1'b0;
        repeat (2) @(negedge clk);
        test_reset_default();
        sys_rst = 1'b0;
        wait_release(n);
        test_boot_codes();
        test_supervisors();
        test_decode();
        conclude();
    end
endmodule
`default_nettype wire
